// ### rtl/pms_pkg.sv
package pms_pkg;
    // clock figures and memory block size
    localparam real SYS_CLK_MHZ      = 200.0;
    localparam real HOST_SCLK_MAX_MHZ = 8.0;
    localparam real FAST_RO_MHZ      = 12.0;
    localparam real HS_XTAL_LO_MHZ   = 16.0;
    localparam real HS_XTAL_HI_MHZ   = 32.0;
    localparam int  MEM_BLOCK_KB     = 6;
    // longest transition times, no low-speed source in use
    localparam real RESET_ACTIVE_MAX_MS   = 1.5;
    localparam real STANDBY_ACTIVE_MAX_MS = 0.42;
    localparam int  RESET_ACTIVE_CYC =
        int'($floor(RESET_ACTIVE_MAX_MS * 1000.0 * SYS_CLK_MHZ));
    localparam int  STANDBY_ACTIVE_CYC =
        int'($floor(STANDBY_ACTIVE_MAX_MS * 1000.0 * SYS_CLK_MHZ));
    localparam int  CNT_W      = 19;
    localparam int  SLEEP_W    = 24;
    localparam int  BYTE_W     = 8;
    localparam int  BITCNT_W   = 3;
    // reset values
    localparam logic [2:0]        SYNC_LO_RST = 3'h0;
    localparam logic [2:0]        SYNC_HI_RST = 3'h7;
    localparam logic [BYTE_W-1:0] BYTE_RST    = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST     = 19'h0;
    localparam logic [SLEEP_W-1:0] SLEEP_RST  = 24'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 3'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST = 3'h7;

    typedef enum logic [2:0] {
        PMS_MODE_RESET, PMS_MODE_STANDBY, PMS_MODE_SLEEP,
        PMS_MODE_ACTIVE, PMS_MODE_RX, PMS_MODE_TX
    } pms_mode_t;

    typedef enum logic [2:0] {
        PMS_ST_BOOT, PMS_ST_WAKE, PMS_ST_SWITCH, PMS_ST_ACTIVE,
        PMS_ST_SLEEP, PMS_ST_STANDBY, PMS_ST_RX, PMS_ST_TX
    } pms_fsm_t;
endpackage

// ### rtl/pms_sequencer.sv
`timescale 1ns/1ps
module pms_sequencer
    import pms_pkg::*;
#(
    parameter int RESET_LIMIT   = RESET_ACTIVE_CYC,
    parameter int STANDBY_LIMIT = STANDBY_ACTIVE_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               host_sclk,
    input  wire logic               slave_select_n,
    input  wire logic               host_mosi,
    output logic                    host_miso,
    output logic                    host_miso_oe_n,
    output logic                    host_data_pending,
    output logic                    host_data_pending_oe_n,
    input  wire logic [BYTE_W-1:0]  tx_byte,
    input  wire logic               tx_valid,
    output logic                    tx_ready,
    output logic [BYTE_W-1:0]       rx_byte,
    output logic                    rx_valid,
    input  wire logic               req_sleep,
    input  wire logic               req_standby,
    input  wire logic               req_rx,
    input  wire logic               req_tx,
    input  wire logic               req_active,
    input  wire logic [SLEEP_W-1:0] sleep_ticks,
    input  wire logic               switchable_memory_off_in_sleep,
    input  wire logic               low_speed_src_xtal,
    input  wire logic               hs_xtal_stable,
    output pms_mode_t               mode,
    output logic                    ldo_on,
    output logic                    low_speed_oscillator_en,
    output logic                    low_speed_sel_xtal,
    output logic                    high_speed_oscillator_en,
    output logic                    fast_ro_en,
    output logic                    clk_sel_fast_ro,
    output logic                    clk_sel_hs_xtal,
    output logic                    core_run,
    output logic                    synth_en,
    output logic                    rx_chain_en,
    output logic                    tx_chain_en,
    output logic                    retained_memory_block_pwr,
    output logic                    switchable_memory_block_pwr,
    output logic                    activation_late
);

    typedef struct packed {
        pms_fsm_t          state;
        pms_mode_t         mode;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  limit;
        logic [SLEEP_W-1:0] sleep_cnt;
        logic              late;
        logic [2:0]        hs_sync;
        logic              hs_q;
        logic [2:0]        ss_sync;
        logic              ss_q;
        logic [2:0]        rt_sync;
        logic              rt_seen;
        logic [BYTE_W-1:0] tx_data;
        logic              pending;
        logic [BYTE_W-1:0] rx_data;
        logic              rx_valid;
        logic              switchable_memory_block_off;
        logic              ls_xtal;
        logic              ldo;
        logic              ls_en;
        logic              hs_en;
        logic              ro_en;
        logic              sel_ro;
        logic              sel_xtal;
        logic              core;
        logic              synth;
        logic              rxc;
        logic              txc;
        logic              switchable_memory_block;
        logic              spi_on;
    } pms_sys_t;

    typedef struct packed {
        logic [BYTE_W-1:0] shift;
        logic [BYTE_W-1:0] rx_hold;
        logic              rx_tgl;
    } pms_link_t;

    localparam pms_sys_t SYS_RST = '{
        state: PMS_ST_BOOT, mode: PMS_MODE_RESET, cnt: CNT_RST, limit: CNT_W'(RESET_LIMIT),
        sleep_cnt: SLEEP_RST, late: 1'b0, hs_sync: SYNC_LO_RST, hs_q: 1'b0,
        ss_sync: SYNC_HI_RST, ss_q: 1'b1, rt_sync: SYNC_LO_RST, rt_seen: 1'b0,
        tx_data: BYTE_RST, pending: 1'b0, rx_data: BYTE_RST, rx_valid: 1'b0,
        switchable_memory_block_off: 1'b0, ls_xtal: 1'b0, ldo: 1'b0, ls_en: 1'b0, hs_en: 1'b0,
        ro_en: 1'b0, sel_ro: 1'b0, sel_xtal: 1'b0, core: 1'b0, synth: 1'b0,
        rxc: 1'b0, txc: 1'b0, switchable_memory_block: 1'b0, spi_on: 1'b0};

    localparam pms_link_t LINK_RST = '{shift: BYTE_RST, rx_hold: BYTE_RST,
                                       rx_tgl: 1'b0};

    pms_sys_t                sys_reg;
    pms_sys_t                sys_next;
    pms_link_t               link_reg;
    pms_link_t               link_next;
    logic [BITCNT_W-1:0]     bit_cnt_reg;
    logic                    rx_event;
    logic                    ss_fall;

    // sliced lock-step: filtered flag follows when stage two and three agree
    function automatic logic pms_filt(input logic [2:0] s, input logic q);
        return (s[1] == s[2]) ? s[2] : q;
    endfunction

    // link side: frame counter, cleared by the frame's own select
    always_ff @(posedge host_sclk or negedge rst_n or posedge slave_select_n) begin
        if (!rst_n || slave_select_n) begin
            bit_cnt_reg <= BITCNT_RST;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    always_comb begin
        link_next = link_reg;
        link_next.shift = {link_reg.shift[BYTE_W-2:0], host_mosi};
        if (bit_cnt_reg == BITCNT_LAST) begin
            link_next.rx_hold = {link_reg.shift[BYTE_W-2:0], host_mosi};
            link_next.rx_tgl  = ~link_reg.rx_tgl;
        end
    end

    always_ff @(posedge host_sclk or negedge rst_n) begin
        if (!rst_n) begin
            link_reg <= LINK_RST;
        end else begin
            link_reg <= link_next;
        end
    end

    // outgoing byte is quasi-static: loaded only while select is idle
    assign host_miso      = sys_reg.tx_data[3'h7 - bit_cnt_reg];
    assign host_miso_oe_n = ~(sys_reg.spi_on & ~slave_select_n);
    assign host_data_pending      = sys_reg.pending;
    assign host_data_pending_oe_n = ~sys_reg.spi_on;

    assign rx_event = (sys_reg.rt_sync[1] == sys_reg.rt_sync[2])
                      && (sys_reg.rt_sync[2] != sys_reg.rt_seen);
    assign ss_fall  = sys_reg.ss_q && !pms_filt(sys_reg.ss_sync, sys_reg.ss_q);
    assign tx_ready = sys_reg.spi_on && !sys_reg.pending && sys_reg.ss_q;

    always_comb begin
        sys_next = sys_reg;
        sys_next.hs_sync = {sys_reg.hs_sync[1:0], hs_xtal_stable};
        sys_next.hs_q    = pms_filt(sys_reg.hs_sync, sys_reg.hs_q);
        sys_next.ss_sync = {sys_reg.ss_sync[1:0], slave_select_n};
        sys_next.ss_q    = pms_filt(sys_reg.ss_sync, sys_reg.ss_q);
        sys_next.rt_sync = {sys_reg.rt_sync[1:0], link_reg.rx_tgl};
        sys_next.rx_valid = 1'b0;
        sys_next.late     = 1'b0;
        // received bytes go only to the command port, never to memory
        if (rx_event) begin
            sys_next.rt_seen  = sys_reg.rt_sync[2];
            sys_next.rx_data  = link_reg.rx_hold;
            sys_next.rx_valid = 1'b1;
            sys_next.pending  = 1'b0;
        end
        if (tx_valid && tx_ready) begin
            sys_next.tx_data = tx_byte;
            sys_next.pending = 1'b1;
        end
        case (sys_reg.state)
            PMS_ST_BOOT, PMS_ST_WAKE: begin
                sys_next.cnt = sys_reg.cnt + 19'h1;
                if (sys_reg.cnt == sys_reg.limit) begin
                    sys_next.late = 1'b1;
                end
                if (sys_reg.hs_q) begin
                    sys_next.state = PMS_ST_SWITCH;
                end
            end
            PMS_ST_SWITCH: begin
                sys_next.state = PMS_ST_ACTIVE;
            end
            PMS_ST_ACTIVE: begin
                if (req_sleep) begin
                    sys_next.state     = PMS_ST_SLEEP;
                    sys_next.sleep_cnt = sleep_ticks;
                    sys_next.switchable_memory_block_off  = switchable_memory_off_in_sleep;
                    sys_next.ls_xtal   = low_speed_src_xtal;
                end else if (req_standby) begin
                    sys_next.state    = PMS_ST_STANDBY;
                    sys_next.switchable_memory_block_off = switchable_memory_off_in_sleep;
                end else if (req_rx) begin
                    sys_next.state = PMS_ST_RX;
                end else if (req_tx) begin
                    sys_next.state = PMS_ST_TX;
                end
            end
            PMS_ST_SLEEP: begin
                sys_next.sleep_cnt = sys_reg.sleep_cnt - 24'h1;
                if (ss_fall || sys_reg.sleep_cnt == SLEEP_RST) begin
                    sys_next.state = PMS_ST_WAKE;
                    sys_next.limit = CNT_W'(STANDBY_LIMIT);
                    sys_next.cnt   = CNT_RST;
                end
            end
            PMS_ST_STANDBY: begin
                if (ss_fall) begin
                    sys_next.state = PMS_ST_WAKE;
                    sys_next.limit = CNT_W'(STANDBY_LIMIT);
                    sys_next.cnt   = CNT_RST;
                end
            end
            PMS_ST_RX, PMS_ST_TX: begin
                if (req_active) begin
                    sys_next.state = PMS_ST_ACTIVE;
                end
            end
            default: begin
                sys_next.state = PMS_ST_BOOT;
            end
        endcase
        if (sys_reg.state == PMS_ST_BOOT && sys_reg.cnt == CNT_RST) begin
            sys_next.limit = CNT_W'(RESET_LIMIT);
        end
        // power and clock controls follow the next state
        sys_next.ldo      = 1'b1;
        sys_next.spi_on   = 1'b0;
        sys_next.ls_en    = 1'b0;
        sys_next.hs_en    = 1'b0;
        sys_next.ro_en    = 1'b0;
        sys_next.sel_ro   = 1'b0;
        sys_next.sel_xtal = 1'b0;
        sys_next.core     = 1'b0;
        sys_next.synth    = 1'b0;
        sys_next.rxc      = 1'b0;
        sys_next.txc      = 1'b0;
        sys_next.switchable_memory_block     = 1'b1;
        case (sys_next.state)
            PMS_ST_BOOT, PMS_ST_WAKE: begin
                sys_next.mode   = (sys_next.state == PMS_ST_BOOT) ? PMS_MODE_RESET
                                                                  : sys_reg.mode;
                sys_next.hs_en  = 1'b1;
                sys_next.ro_en  = 1'b1;
                sys_next.sel_ro = 1'b1;
            end
            PMS_ST_SWITCH: begin
                sys_next.hs_en = 1'b1;
                sys_next.ro_en = 1'b1;
            end
            PMS_ST_SLEEP: begin
                sys_next.mode  = PMS_MODE_SLEEP;
                sys_next.ls_en = 1'b1;
                sys_next.switchable_memory_block  = ~sys_next.switchable_memory_block_off;
            end
            PMS_ST_STANDBY: begin
                sys_next.mode = PMS_MODE_STANDBY;
                sys_next.switchable_memory_block = ~sys_next.switchable_memory_block_off;
            end
            default: begin
                sys_next.mode     = (sys_next.state == PMS_ST_RX) ? PMS_MODE_RX :
                                    (sys_next.state == PMS_ST_TX) ? PMS_MODE_TX :
                                    PMS_MODE_ACTIVE;
                sys_next.spi_on   = 1'b1;
                sys_next.hs_en    = 1'b1;
                sys_next.sel_xtal = 1'b1;
                sys_next.core     = 1'b1;
                sys_next.synth    = sys_next.state inside {PMS_ST_RX, PMS_ST_TX};
                sys_next.rxc      = sys_next.state == PMS_ST_RX;
                sys_next.txc      = sys_next.state == PMS_ST_TX;
            end
        endcase
    end

    // reset holds every supply, clock and chain off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reg <= SYS_RST;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign mode                        = sys_reg.mode;
    assign ldo_on                      = sys_reg.ldo;
    assign low_speed_oscillator_en     = sys_reg.ls_en;
    assign low_speed_sel_xtal          = sys_reg.ls_xtal;
    assign high_speed_oscillator_en    = sys_reg.hs_en;
    assign fast_ro_en                  = sys_reg.ro_en;
    assign clk_sel_fast_ro             = sys_reg.sel_ro;
    assign clk_sel_hs_xtal             = sys_reg.sel_xtal;
    assign core_run                    = sys_reg.core;
    assign synth_en                    = sys_reg.synth;
    assign rx_chain_en                 = sys_reg.rxc;
    assign tx_chain_en                 = sys_reg.txc;
    assign retained_memory_block_pwr   = sys_reg.ldo;
    assign switchable_memory_block_pwr = sys_reg.switchable_memory_block;
    assign rx_byte                     = sys_reg.rx_data;
    assign rx_valid                    = sys_reg.rx_valid;
    assign activation_late             = sys_reg.late;

    // checks
    property p_float_low_power;
        @(posedge sys_clk) disable iff (!rst_n)
        mode inside {PMS_MODE_SLEEP, PMS_MODE_STANDBY}
            |-> host_miso_oe_n && host_data_pending_oe_n;
    endproperty
    a_float_low_power: assert property (p_float_low_power)
        else $error("serial pin driven in low power");

    property p_core_needs_xtal;
        @(posedge sys_clk) disable iff (!rst_n)
        core_run |-> clk_sel_hs_xtal && !clk_sel_fast_ro;
    endproperty
    a_core_needs_xtal: assert property (p_core_needs_xtal)
        else $error("core running off crystal");

    property p_break_before_make;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(clk_sel_hs_xtal) |-> !$past(clk_sel_fast_ro);
    endproperty
    a_break_before_make: assert property (p_break_before_make)
        else $error("clock select overlap");

    property p_one_chain;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_chain_en || tx_chain_en) |-> synth_en && !(rx_chain_en && tx_chain_en);
    endproperty
    a_one_chain: assert property (p_one_chain)
        else $error("radio chain combination wrong");

    property p_sleep_clocks;
        @(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_SLEEP |-> !synth_en && !core_run && (fast_ro_en
            ? high_speed_oscillator_en && !low_speed_oscillator_en
            : low_speed_oscillator_en && !high_speed_oscillator_en);
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks)
        else $error("sleep clocking wrong");

    property p_standby_clocks;
        @(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_STANDBY |-> !low_speed_oscillator_en && !core_run;
    endproperty
    a_standby_clocks: assert property (p_standby_clocks)
        else $error("standby clocking wrong");

    property p_active_set;
        @(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_ACTIVE |-> core_run && high_speed_oscillator_en
            && !synth_en && !host_data_pending_oe_n;
    endproperty
    a_active_set: assert property (p_active_set)
        else $error("active set wrong");

    property p_radio_exit;
        @(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_RX |=> mode inside {PMS_MODE_RX, PMS_MODE_ACTIVE};
    endproperty
    a_radio_exit: assert property (p_radio_exit)
        else $error("illegal exit from receive");

    property p_pending_set;
        @(posedge sys_clk) disable iff (!rst_n)
        tx_valid && tx_ready |=> host_data_pending && !tx_ready;
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("pending not raised");

    property p_switchable_memory_block_sleep;
        @(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_ACTIVE && req_sleep && switchable_memory_off_in_sleep
            |=> !switchable_memory_block_pwr && retained_memory_block_pwr;
    endproperty
    a_switchable_memory_block_sleep: assert property (p_switchable_memory_block_sleep)
        else $error("switchable block still powered");

    c_boot:  cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(core_run));
    c_sleep_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_SLEEP ##1 mode != PMS_MODE_SLEEP);
    c_rx_byte: cover property (@(posedge sys_clk) disable iff (!rst_n) rx_valid);
    c_tx_mode: cover property (@(posedge sys_clk) disable iff (!rst_n)
        mode == PMS_MODE_TX);

endmodule // pms_sequencer

// ### sim/pms_host_model.sv
`timescale 1ns/1ps
module pms_host_model (
    output logic      host_sclk,
    output logic      slave_select_n,
    output logic      host_mosi,
    input  wire logic host_miso
);
    localparam int HALF = 90; // three 30 ns link ticks, 5.6 MHz
    initial begin
        host_sclk = 1'b0;
        slave_select_n = 1'b1;
        host_mosi = 1'b0;
    end
    // clock stands still outside frames, mode 0
    task automatic xfer(input logic [7:0] dout, output logic [7:0] din);
        din = 8'h00;
        slave_select_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            host_mosi = dout[i]; // msb first, full duplex
            #(HALF);
            din = {din[6:0], host_miso};
            host_sclk = 1'b1;
            #(HALF);
            host_sclk = 1'b0;
        end
        #(HALF);
        host_mosi = ~host_mosi;
        slave_select_n = 1'b1;
        #(HALF);
    endtask
    task automatic wake();
        slave_select_n = 1'b0;
        #120;
        slave_select_n = 1'b1;
    endtask
endmodule // pms_host_model

// ### sim/test_power_mode_sequencer_host_wake.sv
`timescale 1ns/1ps
module test_power_mode_sequencer_host_wake;
    import pms_pkg::*;
    localparam int RL = 40;
    localparam int SL = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b1;
    logic host_sclk, slave_select_n, host_mosi, host_miso, miso_line;
    logic host_miso_oe_n, host_data_pending, host_data_pending_oe_n;
    logic [7:0] tx_byte, rx_byte, rx_got, b, d, got;
    logic tx_valid, tx_ready, rx_valid, mem_off, ls_xtal, hs_xtal_stable, sb;
    logic [4:0] req;
    logic [23:0] sleep_ticks;
    logic [3:0] xo_sh;
    pms_mode_t mode;
    logic ldo_on, low_speed_oscillator_en, low_speed_sel_xtal, high_speed_oscillator_en;
    logic fast_ro_en, clk_sel_fast_ro, clk_sel_hs_xtal, core_run, synth_en, rx_chain_en;
    logic tx_chain_en, retained_memory_block_pwr, switchable_memory_block_pwr, activation_late;
    int fail_count = 0;
    int n_tests = 0;
    int bad_cnt = 0;
    int rx_cnt = 0;
    int n;
    always #2.5 sys_clk = ~sys_clk;
    assign miso_line = host_miso_oe_n ? 1'b0 : host_miso; // pull-down when floating
    assign hs_xtal_stable = xo_sh[3];
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n) xo_sh <= 4'h0;
        else xo_sh <= {xo_sh[2:0], high_speed_oscillator_en};
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            rx_got <= rx_byte;
            rx_cnt <= rx_cnt + 1;
        end
        if (rst_n && (activation_late !== 1'b0
            || (clk_sel_fast_ro && clk_sel_hs_xtal) !== 1'b0
            || (core_run && !clk_sel_hs_xtal) !== 1'b0)) bad_cnt <= bad_cnt + 1;
    end
    pms_sequencer #(.RESET_LIMIT(RL), .STANDBY_LIMIT(SL)) dut (
        .sys_clk, .rst_n, .host_sclk, .slave_select_n, .host_mosi, .host_miso,
        .host_miso_oe_n, .host_data_pending, .host_data_pending_oe_n, .tx_byte,
        .tx_valid, .tx_ready, .rx_byte, .rx_valid, .req_sleep(req[0]),
        .req_standby(req[1]), .req_rx(req[2]), .req_tx(req[3]), .req_active(req[4]),
        .sleep_ticks, .switchable_memory_off_in_sleep(mem_off),
        .low_speed_src_xtal(ls_xtal), .hs_xtal_stable, .mode, .ldo_on,
        .low_speed_oscillator_en, .low_speed_sel_xtal, .high_speed_oscillator_en,
        .fast_ro_en, .clk_sel_fast_ro, .clk_sel_hs_xtal, .core_run, .synth_en,
        .rx_chain_en, .tx_chain_en, .retained_memory_block_pwr,
        .switchable_memory_block_pwr, .activation_late);
    pms_host_model u_host (.host_sclk, .slave_select_n, .host_mosi, .host_miso(miso_line));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_mode(input pms_mode_t m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(mode, m);
        if (mode !== m) final_report();
    endtask
    task automatic go(input int i, input pms_mode_t m);
        @(posedge sys_clk) req[i] <= 1'b1;
        wait_mode(m, 4);
        @(posedge sys_clk) req[i] <= 1'b0;
        #1;
    endtask
    initial begin
        #400us;
        fail_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'h0280b316));
        rst_n <= 1'b0;
        {tx_byte, tx_valid, req, sleep_ticks, mem_off, ls_xtal} = '0;
        repeat (5) @(posedge sys_clk);
        #1 chk({mode, ldo_on, core_run, host_miso_oe_n}, {PMS_MODE_RESET, 3'b001});
        @(posedge sys_clk) rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk({fast_ro_en, clk_sel_fast_ro, core_run}, 3'b110);
        wait_mode(PMS_MODE_ACTIVE, RL);
        chk({ldo_on, high_speed_oscillator_en, core_run, synth_en, rx_chain_en, tx_chain_en,
             clk_sel_hs_xtal}, 7'b1110001);
        for (int r = 2; r < 4; r++) begin
            go(r, r == 2 ? PMS_MODE_RX : PMS_MODE_TX);
            chk({synth_en, rx_chain_en, tx_chain_en}, r == 2 ? 3'b110 : 3'b101);
            @(posedge sys_clk) req[5-r] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 chk(mode, r == 2 ? PMS_MODE_RX : PMS_MODE_TX);
            @(posedge sys_clk) req[5-r] <= 1'b0;
            go(4, PMS_MODE_ACTIVE);
        end
        for (int k = 0; k < 4; k++) begin
            sb = k[0];
            @(posedge sys_clk) begin
                sleep_ticks <= (k == 2) ? 24'hffffff : 24'($urandom_range(30, 60));
                mem_off <= 1'($urandom);
                ls_xtal <= 1'($urandom);
            end
            go(sb, sb ? PMS_MODE_STANDBY : PMS_MODE_SLEEP);
            chk({low_speed_oscillator_en, high_speed_oscillator_en, core_run, synth_en,
                 retained_memory_block_pwr}, {!sb, 4'b0001});
            chk(switchable_memory_block_pwr, !mem_off);
            if (!sb) chk(low_speed_sel_xtal, ls_xtal);
            chk({host_miso_oe_n, host_data_pending_oe_n}, 2'b11);
            if (sb) begin
                repeat (100) @(posedge sys_clk);
                #1 chk(mode, PMS_MODE_STANDBY);
                u_host.wake();
            end
            if (k == 2) u_host.wake();
            wait_mode(PMS_MODE_ACTIVE, 60 + 2 * SL);
        end
        for (int k = 0; k < 5; k++) begin
            b = k == 0 ? 8'hff : 8'($urandom);
            d = k == 0 ? 8'h00 : 8'($urandom);
            @(posedge sys_clk) begin
                tx_byte <= b;
                tx_valid <= 1'b1;
            end
            #1;
            for (int j = 0; j < 50 && tx_ready !== 1'b1; j++) @(posedge sys_clk) #1;
            chk(tx_ready, 1'b1);
            @(posedge sys_clk) tx_valid <= 1'b0;
            #1 chk(host_data_pending, 1'b1);
            n = rx_cnt;
            u_host.xfer(d, got);
            chk(got, b);
            for (int j = 0; j < 20 && rx_cnt == n; j++) @(posedge sys_clk) #1;
            chk(rx_cnt, n + 1);
            chk({rx_got, host_data_pending}, {d, 1'b0});
        end
        chk(bad_cnt, 0);
        final_report();
    end
endmodule // test_power_mode_sequencer_host_wake
